// ===== core/interrupt_status_collector.sv
// Purpose: Collects device events into the interrupt status word on the host bus.
// Assumes: Event inputs are pulses or levels from logic on core_clk; pins are not.
// Notes: Mask, deassertion timer and pin driver sit outside; the mask arrives as a port.
// Notes on behaviour
// - Host writing one to a status bit other than bit 18 clears it; host writes one to acknowledge.
// - Software bit 31 sets while software event enable is high; write one clears.
// - Bit 25 sets when transmit stop is requested and transmitter has halted.
// - Bit 24 sets when the receive engine has halted.
// - Bit 23 sets when the drop counter steps from 7FFFFFFFh to 80000000h.
// - Bit 21 sets when a completion-flagged transmit buffer is fully loaded.
// - Bit 20 sets when the programmed receive DMA length has been read out.
// - Bit 19 sets when the general timer wraps from zero to FFFFh.
// - Bit 18 mirrors the PHY event and ignores host writes.
// - Bit 17 sets on a power event regardless of wake output; write one clears.
// - Power events never wake the device; only a byte-test register write does.
// - The power event interrupt is never held back by the deassertion interval.
// - Bit 16 sets when the transmit status FIFO overflows.
// - Bit 15 sets when a received packet exceeds 2048 bytes.
// - Bit 14 sets when the receive engine reports an error.
// - Bit 13 sets when the transmit engine reports an error.
// - Bit 10 sets on a transmit data FIFO write while that FIFO is full.
// - Bit 9 sets while transmit data free space exceeds its level.
// - Bit 8 sets on transmit status full; bit 7 while its used count exceeds its level.
// - Bit 6 sets each time a received frame is dropped.
// - Bit 4 sets on receive status full; bit 3 while its used count exceeds its level.
// - Bits 2 to 0 latch selected pin edges; write one clears each.
// - Status bits show events regardless of the enable mask.
// - Master indication is high whenever an enabled status bit is active.
`timescale 1ns/100ps
module interrupt_status_collector (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rd_valid,
    input wire logic [31:0] interrupt_enable_mask,
    input wire logic software_event_enable,
    input wire logic transmit_stop_request,
    input wire logic transmit_halted,
    input wire logic receive_halted,
    input wire logic drop_count_inc,
    input wire logic [31:0] drop_count,
    input wire logic tx_buffer_loaded,
    input wire logic completion_notify_flag,
    input wire logic receive_dma_done,
    input wire logic timer_tick,
    input wire logic [15:0] timer_count,
    input wire logic phy_event,
    input wire logic power_event_detect,
    input wire logic transmit_status_overflow,
    input wire logic rx_frame_end,
    input wire logic [15:0] rx_frame_bytes,
    input wire logic receive_error,
    input wire logic transmit_error,
    input wire logic tx_data_write,
    input wire logic tx_data_full,
    input wire logic [7:0] tx_data_free_blocks,
    input wire logic [7:0] tx_space_level,
    input wire logic tx_status_full,
    input wire logic [7:0] tx_status_used,
    input wire logic [7:0] tx_status_level,
    input wire logic frame_dropped,
    input wire logic rx_status_full,
    input wire logic [7:0] rx_status_used,
    input wire logic [7:0] rx_status_level,
    input wire logic [2:0] gpio_pin_in,
    input wire logic [2:0] gpio_rise_select,
    output logic master_irq,
    output logic power_event_irq,
    output logic wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic [1:0] rst_sync_ff;
    logic [1:0] nxt_rst_sync;
    logic sys_rst_b;

    // Shift ones in after the release so the core leaves reset on a clean edge.
    always_comb begin
        nxt_rst_sync = {rst_sync_ff[0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    assign sys_rst_b = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs: three flip-flops, a level counts once stages two and three agree.
    logic [2:0] pin_s1_ff;
    logic [2:0] pin_s2_ff;
    logic [2:0] pin_s3_ff;
    logic [2:0] pin_stable_ff;
    logic [2:0] nxt_pin_stable;
    logic [2:0] pin_event;

    // Stage one feeds stage two only; the filter looks at two and three.
    always_comb begin
        nxt_pin_stable = pin_stable_ff;
        for (int i = 0; i < isc_pkg::PIN_COUNT; i++) begin
            if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                nxt_pin_stable[i] = pin_s3_ff[i];
            end
        end
        // An edge counts only toward the level that the pin's select asks for.
        pin_event = (pin_stable_ff ^ nxt_pin_stable) & ~(nxt_pin_stable ^ gpio_rise_select);
    end

    always_ff @(posedge core_clk or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
            pin_s3_ff <= 3'h0;
            pin_stable_ff <= 3'h0;
        end else begin
            pin_s1_ff <= gpio_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_stable_ff <= nxt_pin_stable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host access decode.
    logic wr_status_hit;
    logic wr_byte_test_hit;
    logic rd_status_hit;

    assign wr_status_hit = host_wr && (host_addr == isc_pkg::STATUS_OFF);
    assign wr_byte_test_hit = host_wr && (host_addr == isc_pkg::BYTE_TEST_OFF);
    assign rd_status_hit = host_rd && (host_addr == isc_pkg::STATUS_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Event sources. Levels set every cycle they hold, so a clear under a
    // standing condition is refused by the set, which is what software expects.
    logic [31:0] set_vec;
    logic [31:0] clr_vec;

    always_comb begin
        set_vec = 32'h00000000;
        set_vec[isc_pkg::SOFT_BIT] = software_event_enable;
        set_vec[isc_pkg::TX_HALT_BIT] = transmit_stop_request && transmit_halted;
        set_vec[isc_pkg::RX_HALT_BIT] = receive_halted;
        set_vec[isc_pkg::DROP_HALF_BIT] = drop_count_inc && (drop_count == isc_pkg::DROP_HALF_VALUE);
        set_vec[isc_pkg::TX_DONE_BIT] = tx_buffer_loaded && completion_notify_flag;
        set_vec[isc_pkg::RX_DMA_BIT] = receive_dma_done;
        set_vec[isc_pkg::TIMER_BIT] = timer_tick && (timer_count == isc_pkg::TIMER_ZERO);
        set_vec[isc_pkg::POWER_BIT] = power_event_detect;
        set_vec[isc_pkg::TX_STS_OVF_BIT] = transmit_status_overflow;
        set_vec[isc_pkg::RX_OVERSIZE_BIT] = rx_frame_end && (rx_frame_bytes > isc_pkg::OVERSIZE_BYTES);
        set_vec[isc_pkg::RX_ERR_BIT] = receive_error;
        set_vec[isc_pkg::TX_ERR_BIT] = transmit_error;
        set_vec[isc_pkg::TX_OVERRUN_BIT] = tx_data_write && tx_data_full;
        set_vec[isc_pkg::TX_SPACE_BIT] = tx_data_free_blocks > tx_space_level;
        set_vec[isc_pkg::TX_STS_FULL_BIT] = tx_status_full;
        set_vec[isc_pkg::TX_STS_LVL_BIT] = tx_status_used > tx_status_level;
        set_vec[isc_pkg::FRAME_DROP_BIT] = frame_dropped;
        set_vec[isc_pkg::RX_STS_FULL_BIT] = rx_status_full;
        set_vec[isc_pkg::RX_STS_LVL_BIT] = rx_status_used > rx_status_level;
        set_vec[isc_pkg::PIN_LSB +: isc_pkg::PIN_COUNT] = pin_event;
        // Only ones in write-clear positions clear; zeros and reserved bits do nothing.
        clr_vec = 32'h00000000;
        if (wr_status_hit) begin
            clr_vec = host_wdata & isc_pkg::STICKY_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; the PHY bit is left out of the mask and mirrored below.
    logic [31:0] sticky_q;

    sticky_flags #(
        .WIDTH(32),
        .KEEP_MASK(isc_pkg::STICKY_MASK)
    ) u_flags (
        .core_clk(core_clk),
        .sys_rst_b(sys_rst_b),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .flags(sticky_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status word, outputs and read data.
    logic phy_ff;
    logic nxt_phy;
    logic [31:0] status_vec;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rd_valid_ff;
    logic master_irq_ff;
    logic nxt_master_irq;
    logic power_irq_ff;
    logic nxt_power_irq;
    logic wake_ff;
    logic nxt_wake;

    // The mask is never applied here, so software sees every source.
    always_comb begin
        status_vec = sticky_q;
        status_vec[isc_pkg::PHY_BIT] = phy_ff;
    end

    // Next values of the read data and the indications.
    always_comb begin
        nxt_phy = phy_event;
        nxt_rdata = 32'h00000000;
        if (rd_status_hit) begin
            nxt_rdata = status_vec & isc_pkg::IMPL_MASK;
        end
        nxt_master_irq = |(status_vec & interrupt_enable_mask);
        // Straight from the flag: no interval timer may stand in this path.
        nxt_power_irq = status_vec[isc_pkg::POWER_BIT] && interrupt_enable_mask[isc_pkg::POWER_BIT];
        // Waking depends on the byte-test write alone, never on the power flag.
        nxt_wake = wr_byte_test_hit;
    end

    always_ff @(posedge core_clk or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            phy_ff <= 1'b0;
            rdata_ff <= isc_pkg::STATUS_RESET;
            rd_valid_ff <= 1'b0;
            master_irq_ff <= 1'b0;
            power_irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            phy_ff <= nxt_phy;
            rdata_ff <= nxt_rdata;
            rd_valid_ff <= host_rd;
            master_irq_ff <= nxt_master_irq;
            power_irq_ff <= nxt_power_irq;
            wake_ff <= nxt_wake;
        end
    end

    assign host_rdata = rdata_ff;
    assign host_rd_valid = rd_valid_ff;
    assign master_irq = master_irq_ff;
    assign power_event_irq = power_irq_ff;
    assign wake_request = wake_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the collector.
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!sys_rst_b);

    // A one written without a competing event leaves the bit clear.
    chk_write_one_clears: assert property (
        wr_status_hit |=> ((sticky_q & $past(clr_vec) & ~$past(set_vec)) == 32'h00000000)
    ) else $error("status bit survived a write-one clear");

    // The software bit follows its enable within one cycle.
    chk_soft_bit_set: assert property (
        software_event_enable |=> status_vec[isc_pkg::SOFT_BIT]
    ) else $error("software bit not set while enabled");

    // Transmit halt needs both the stop request and the halted engine.
    chk_tx_halt_set: assert property (
        (!$past(status_vec[isc_pkg::TX_HALT_BIT]) && !(transmit_stop_request && transmit_halted)
         && !$past(transmit_stop_request && transmit_halted)) |-> !status_vec[isc_pkg::TX_HALT_BIT]
    ) else $error("transmit halted bit set without cause");

    // Drop counter crossing its halfway point flags bit 23.
    chk_drop_half_set: assert property (
        (drop_count_inc && drop_count == isc_pkg::DROP_HALF_VALUE) |=> status_vec[isc_pkg::DROP_HALF_BIT]
    ) else $error("drop counter halfway bit missed");

    // A tick on a zero timer count flags the timer wrap bit.
    chk_timer_wrap_set: assert property (
        (timer_tick && timer_count == isc_pkg::TIMER_ZERO) |=> status_vec[isc_pkg::TIMER_BIT]
    ) else $error("timer wrap bit missed");

    // The PHY bit ignores a write of one and keeps showing the source.
    chk_phy_write_ignored: assert property (
        (wr_status_hit && host_wdata[isc_pkg::PHY_BIT] && phy_ff && phy_event)
        |=> status_vec[isc_pkg::PHY_BIT]
    ) else $error("PHY bit cleared by a host write");

    // Oversize frames flag bit 15; a frame of exactly 2048 bytes does not.
    chk_oversize_frame: assert property (
        (rx_frame_end && rx_frame_bytes == isc_pkg::OVERSIZE_BYTES && !sticky_q[isc_pkg::RX_OVERSIZE_BIT])
        |=> !sticky_q[isc_pkg::RX_OVERSIZE_BIT]
    ) else $error("oversize bit set for a legal length");

    // Bits written with zero keep their value; reserved bits stay zero.
    chk_zero_keeps_bit: assert property (
        wr_status_hit |=> (((sticky_q & $past(sticky_q & ~host_wdata)) == $past(sticky_q & ~host_wdata))
                           && ((status_vec & ~isc_pkg::IMPL_MASK) == 32'h00000000))
    ) else $error("zero write or reserved bit changed status");

    // Set beats clear when both land together.
    chk_set_beats_clear: assert property (
        ((set_vec & clr_vec) != 32'h00000000) |=> ((sticky_q & $past(set_vec & clr_vec)) == $past(set_vec & clr_vec))
    ) else $error("event lost to a simultaneous clear");

    // Master indication tracks enabled bits one cycle later, both ways.
    chk_master_follows: assert property (
        master_irq == $past(|(status_vec & interrupt_enable_mask)) ##1 1'b1
    ) else $error("master indication disagrees with enabled status");

    // Wake comes from a byte-test write and from nothing else.
    chk_wake_source: assert property (
        wake_request |-> $past(wr_byte_test_hit)
    ) else $error("wake request without a byte-test write");

    // A power event flags bit 17 whatever the wake output does.
    chk_power_bit_set: assert property (
        power_event_detect |=> status_vec[isc_pkg::POWER_BIT]
    ) else $error("power event bit missed");

    // The power indication follows its flag with no interval in the path.
    chk_power_irq_direct: assert property (
        power_event_irq == $past(status_vec[isc_pkg::POWER_BIT] && interrupt_enable_mask[isc_pkg::POWER_BIT])
    ) else $error("power indication delayed or wrong");

    // A selected pin edge lands in its status bit at the next edge.
    chk_pin_event_set: assert property (
        (pin_event != 3'h0) |=> ((sticky_q[2:0] & $past(pin_event)) == $past(pin_event))
    ) else $error("pin event not latched");

    // A status read answers next cycle with the implemented bits only.
    chk_read_data_status: assert property (
        rd_status_hit |=> (host_rd_valid && (host_rdata == $past(status_vec & isc_pkg::IMPL_MASK)))
    ) else $error("status read data wrong");

    cover_clear_race: cover property ((set_vec & clr_vec) != 32'h00000000);
    cover_master_rise: cover property ($rose(master_irq));
    cover_pin_event: cover property (pin_event != 3'h0);
    cover_wake: cover property (wake_request);
    cover_power_irq: cover property (power_event_irq);

endmodule

// ===== core/isc_pkg.sv
// Purpose: Shared constants of the interrupt status collector.
// Assumes: Byte offsets on an 8-bit host address; 32-bit register data.
// Notes: Bit positions index the interrupt status word.
package isc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the host bus.
    localparam logic [7:0] STATUS_OFF = 8'h58;
    localparam logic [7:0] BYTE_TEST_OFF = 8'h64;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions inside the interrupt status word.
    localparam int SOFT_BIT = 31;
    localparam int TX_HALT_BIT = 25;
    localparam int RX_HALT_BIT = 24;
    localparam int DROP_HALF_BIT = 23;
    localparam int TX_DONE_BIT = 21;
    localparam int RX_DMA_BIT = 20;
    localparam int TIMER_BIT = 19;
    localparam int PHY_BIT = 18;
    localparam int POWER_BIT = 17;
    localparam int TX_STS_OVF_BIT = 16;
    localparam int RX_OVERSIZE_BIT = 15;
    localparam int RX_ERR_BIT = 14;
    localparam int TX_ERR_BIT = 13;
    localparam int TX_OVERRUN_BIT = 10;
    localparam int TX_SPACE_BIT = 9;
    localparam int TX_STS_FULL_BIT = 8;
    localparam int TX_STS_LVL_BIT = 7;
    localparam int FRAME_DROP_BIT = 6;
    localparam int RX_STS_FULL_BIT = 4;
    localparam int RX_STS_LVL_BIT = 3;
    localparam int PIN_LSB = 0;
    localparam int PIN_COUNT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Masks and reset values.
    localparam logic [31:0] IMPL_MASK = 32'h83BFE7DF;
    localparam logic [31:0] STICKY_MASK = 32'h83BBE7DF;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Event thresholds.
    localparam logic [31:0] DROP_HALF_VALUE = 32'h7FFFFFFF;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
    localparam logic [15:0] OVERSIZE_BYTES = 16'h0800;

endpackage

// ===== core/sticky_flags.sv
// Purpose: Bank of sticky event flags with write-one clear.
// Assumes: Set and clear vectors come from logic on the same clock.
// Notes: A set in the cycle of a clear wins, so no event is lost.
`timescale 1ns/100ps
module sticky_flags #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] KEEP_MASK = '1
) (
    input wire logic core_clk,
    input wire logic sys_rst_b,
    input wire logic [WIDTH-1:0] set_vec,
    input wire logic [WIDTH-1:0] clr_vec,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    ////////////////////////////////////////////////////////////////////////////
    // Clear first, then set, so the set has the last word.
    always_comb begin
        nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & KEEP_MASK;
    end

    // Plain register stage for the flags.
    always_ff @(posedge core_clk or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;

endmodule

// ===== dv/host_model.sv
// Purpose: Host CPU model on the register bus of the status collector.
// Assumes: One request at a time, no wait states, answer one cycle after a read.
// Notes: Address and data are inverted after release so stale values never match.
`timescale 1ns/100ps
module host_model (
    input wire logic core_clk,
    input wire logic [31:0] host_rdata,
    input wire logic host_rd_valid,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [31:0] host_wdata
);
    // The bus is idle from time zero until a task drives it.
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 8'h00;
        host_wdata = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A write of ones acknowledges the handled events.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge core_clk);
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask

    // The answer is taken one cycle after the read edge, while valid stands.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge core_clk);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge core_clk);
        host_rd <= 1'b0;
        host_addr <= ~a;
        #1;
        v = host_rd_valid;
        d = host_rdata;
    endtask
endmodule

// ===== dv/interrupt_status_collector_tb.sv
// Purpose: Self-checking bench of the interrupt status collector.
// Assumes: Event inputs change by non-blocking assignment at the rising edge.
// Notes: Each of the 19 listed event sources is tried with its true condition and a near miss.
`timescale 1ns/100ps
module interrupt_status_collector_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] host_rdata, mask = 32'h0, drop_count = 32'h0;
    logic host_rd_valid, host_wr, host_rd, master_irq, power_event_irq, wake_request;
    logic [7:0] host_addr, tx_free = 8'h00, tx_used = 8'h00, rx_used = 8'h00;
    logic [31:0] host_wdata, d;
    logic v;
    logic sw_en = 0, stop_req = 0, tx_halt = 0, rx_halt = 0, drop_inc = 0, loaded = 0, notify = 0;
    logic dma = 0, tick = 0, phy = 0, pwr = 0, ovf = 0, fend = 0, rx_err = 0, tx_err = 0;
    logic tx_wr = 0, tx_full = 0, ts_full = 0, fdrop = 0, rs_full = 0;
    logic [15:0] tcount = 16'h0000, fbytes = 16'h0000;
    logic [2:0] pins = 3'b010;
    int error_cnt = 0, cmp_count = 0;
    int bits[19] = '{31, 25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6, 4, 3};

    // The clock toggles every 25 ns, half of its 50 ns period.
    always #25 core_clk = ~core_clk;

    interrupt_status_collector u_interrupt_status_collector (
        .core_clk(core_clk), .rst_b(rst_b), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rd_valid(host_rd_valid), .interrupt_enable_mask(mask),
        .software_event_enable(sw_en), .transmit_stop_request(stop_req),
        .transmit_halted(tx_halt), .receive_halted(rx_halt), .drop_count_inc(drop_inc),
        .drop_count(drop_count), .tx_buffer_loaded(loaded), .completion_notify_flag(notify),
        .receive_dma_done(dma), .timer_tick(tick), .timer_count(tcount), .phy_event(phy),
        .power_event_detect(pwr), .transmit_status_overflow(ovf), .rx_frame_end(fend),
        .rx_frame_bytes(fbytes), .receive_error(rx_err), .transmit_error(tx_err),
        .tx_data_write(tx_wr), .tx_data_full(tx_full), .tx_data_free_blocks(tx_free),
        .tx_space_level(8'h08), .tx_status_full(ts_full), .tx_status_used(tx_used),
        .tx_status_level(8'h04), .frame_dropped(fdrop), .rx_status_full(rs_full),
        .rx_status_used(rx_used), .rx_status_level(8'h04), .gpio_pin_in(pins),
        .gpio_rise_select(3'b101), .master_irq(master_irq),
        .power_event_irq(power_event_irq), .wake_request(wake_request));

    host_model u_host_model (
        .core_clk(core_clk), .host_rdata(host_rdata), .host_rd_valid(host_rd_valid),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata));

    ////////////////////////////////////////////////////////////////////////////
    // Case equality keeps an unknown from passing as a match.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic status(input logic [31:0] exp);
        u_host_model.rd(8'h58, d, v);
        check(v, 1'b1);
        check(d, exp);
    endtask

    // Near-miss values sit exactly on each boundary, so an off-by-one shows.
    task automatic drive(input int i, input bit p, input bit on);
        case (i)
            0: sw_en <= on & p;
            1: begin stop_req <= on; tx_halt <= on & p; end
            2: rx_halt <= on & p;
            3: begin drop_inc <= on; drop_count <= p ? 32'h7FFFFFFF : 32'h7FFFFFFE; end
            4: begin loaded <= on; notify <= on & p; end
            5: dma <= on & p;
            6: begin tick <= on; tcount <= p ? 16'h0000 : 16'h0001; end
            7: pwr <= on & p;
            8: ovf <= on & p;
            9: begin fend <= on; fbytes <= p ? 16'h0801 : 16'h0800; end
            10: rx_err <= on & p;
            11: tx_err <= on & p;
            12: begin tx_wr <= on; tx_full <= on & p; end
            13: tx_free <= on ? (p ? 8'h09 : 8'h08) : 8'h00;
            14: ts_full <= on & p;
            15: tx_used <= on ? (p ? 8'h05 : 8'h04) : 8'h00;
            16: fdrop <= on & p;
            17: rs_full <= on & p;
            default: rx_used <= on ? (p ? 8'h05 : 8'h04) : 8'h00;
        endcase
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Every source sets only its bit; near-miss runs, with the mask at zero, keep the summary low.
    task automatic every_source();
        for (int i = 0; i < 19; i++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge core_clk);
                mask <= p ? 32'hFFFFFFFF : 32'h0;
                drive(i, p, 1);
                @(posedge core_clk);
                drive(i, p, 0);
                status(p ? 32'h1 << bits[i] : 32'h0);
                check(master_irq, p);
                check(wake_request, 1'b0);
                if (i == 7) check(power_event_irq, p);
                u_host_model.wr(8'h58, 32'hFFFFFFFF);
                status(32'h0);
            end
        end
    endtask

    // Zero bits of a write leave their flags alone; a set beats a clear.
    task automatic clear_rules();
        @(posedge core_clk);
        rx_err <= 1'b1;
        rx_halt <= 1'b1;
        u_host_model.wr(8'h58, 32'hFEFFBFFF);
        rx_halt <= 1'b0;
        u_host_model.wr(8'h58, 32'h00004000);
        rx_err <= 1'b0;
        status(32'h01004000);
        u_host_model.wr(8'h58, 32'h00004000);
        status(32'h01000000);
        u_host_model.wr(8'h58, 32'hFFFFFFFF);
    endtask

    // The PHY bit follows its event and ignores clears.
    task automatic phy_mirror();
        @(posedge core_clk);
        phy <= 1'b1;
        u_host_model.wr(8'h58, 32'hFFFFFFFF);
        status(32'h00040000);
        phy <= 1'b0;
        repeat (2) @(posedge core_clk);
        status(32'h0);
    endtask

    // Pin 0 rises and pin 1 falls, both selected; a later fall of pin 0 is not.
    task automatic pin_events();
        @(posedge core_clk);
        pins <= 3'b001;
        repeat (8) @(posedge core_clk);
        status(32'h00000003);
        u_host_model.wr(8'h58, 32'h00000003);
        pins <= 3'b000;
        repeat (8) @(posedge core_clk);
        status(32'h0);
    endtask

    // Only a byte-test write wakes; other offsets read zero but still answer.
    task automatic wake_and_unmapped();
        u_host_model.wr(8'h64, 32'h0);
        #1;
        check(wake_request, 1'b1);
        @(posedge core_clk);
        #1;
        check(wake_request, 1'b0);
        u_host_model.rd(8'hFC, d, v);
        check(v, 1'b1);
        check(d, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset for eight cycles, then three edges, one more than the two the release path needs.
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        status(32'h0);
        every_source();
        clear_rules();
        phy_mirror();
        pin_events();
        wake_and_unmapped();
        stop_test();
    end

    // The tests need under two thousand cycles; ten times that means a hang.
    initial begin
        #(20000 * 50);
        error_cnt++;
        stop_test();
    end
endmodule
